// >>> core/eqca_cfg.svh
// constants and register map of the equalizer coefficient access port
// Operation
// - The coefficient store is one synchronous single-port array of 52 words of 24 bits, reached by the host only through the holding, index and control registers.
// - Once the write is committed to the array, the hardware clears the write launch bit by itself.
// - A write is held back until a cycle in which the audio routines do not use the array, so they keep priority on the port.
// - On finishing a read the hardware copies the addressed word into the read holding register and clears the read launch bit at the same clock edge.
// - Word indices 0x00 to 0x18 hold channel 0 band coefficients and the 25 indices from 0x19 hold channel 1.
// - Each channel has five bands of five consecutive words in the order A1, A2, B0, B1, B2, so band one of channel 0 starts at 0x05.
// - The channel 0 prescaler sits at word 0x32 and the channel 1 prescaler at word 0x33, split into bytes like the band words.
// - The coefficient index register carries a 10-bit word index of which only 0 to 51 map onto words.
// - The read holding register is a read-only 24-bit value showing the word last fetched from the array.
`ifndef EQCA_CFG_SVH
`define EQCA_CFG_SVH
// register byte offsets
`define EQCA_OFF_WHOLD 4'h0
`define EQCA_OFF_RHOLD 4'h4
`define EQCA_OFF_INDEX 4'h8
`define EQCA_OFF_CTRL 4'hc
// access control fields
`define EQCA_BIT_WR 15
`define EQCA_BIT_RD 14
// reset values
`define EQCA_RST_WORD 24'h000000
`define EQCA_RST_HALF 16'h0000
`define EQCA_RST_BUS 32'h00000000
// coefficient map
`define EQCA_WORDS 10'd52
`define EQCA_CH0_BASE 7'h00
`define EQCA_CH1_BASE 7'h19
`define EQCA_BAND_WORDS 7'h05
`define EQCA_PRE_BASE 7'h32
`define EQCA_MAP_WORDS 7'h34
// bus answers
`define EQCA_RESP_OK 2'b00
`define EQCA_RESP_ERR 2'b10
`endif

// >>> core/eqca_pkg.sv
// types shared by the equalizer coefficient access port
package eqca_pkg;
    // audio engine request for one coefficient word
    typedef struct packed {
        logic busy;
        logic pre;
        logic chan;
        logic [2:0] band;
        logic [2:0] coef;
    } eqca_dsp_req_t;
    // access sequencer states, one-hot
    typedef enum logic [1:0] {
        EQCA_IDLE = 2'b01,
        EQCA_PEND = 2'b10
    } eqca_state_t;
endpackage

// >>> core/eqca_top.sv
// equalizer coefficient store with indirect register access over axi4-lite
`timescale 1ns/1ns
`default_nettype none
`include "eqca_cfg.svh"
module eqca_top #(
    parameter int DATA_W = 24,
    parameter int INDEX_W = 10
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // axi4-lite write address and data
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [3:0] awaddr_i,
    input wire logic wvalid_i,
    output logic wready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    // axi4-lite write response
    output logic bvalid_o,
    input wire logic bready_i,
    output logic [1:0] bresp_o,
    // axi4-lite read
    input wire logic arvalid_i,
    output logic arready_o,
    input wire logic [3:0] araddr_i,
    output logic rvalid_o,
    input wire logic rready_i,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    // audio engine coefficient port, same clock
    input wire eqca_pkg::eqca_dsp_req_t dsp_req_i,
    output logic [DATA_W-1:0] dsp_rdata_o
);
    // ****************************************************************
    // storage
    // ****************************************************************
    logic [DATA_W-1:0] mem [0:51];
    logic [DATA_W-1:0] whold_reg;
    logic [DATA_W-1:0] rhold_reg;
    logic [15:0] index_reg;
    logic [15:0] ctrl_reg;
    logic [DATA_W-1:0] dsp_rdata_reg;
    eqca_pkg::eqca_state_t state_reg;
    // ****************************************************************
    // bus registers
    // ****************************************************************
    logic aw_have_reg;
    logic w_have_reg;
    logic [3:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    // ****************************************************************
    // audio engine word decode
    // ****************************************************************
    // channel base plus five words per band, prescalers after both
    wire logic [6:0] dsp_chan_base;
    wire logic [6:0] dsp_idx;
    wire logic dsp_idx_ok;
    assign dsp_chan_base = dsp_req_i.chan ? `EQCA_CH1_BASE : `EQCA_CH0_BASE;
    assign dsp_idx = dsp_req_i.pre ?
        (`EQCA_PRE_BASE + {6'h00, dsp_req_i.chan}) :
        (dsp_chan_base + 7'(dsp_req_i.band) * `EQCA_BAND_WORDS
         + 7'(dsp_req_i.coef));
    // band or coefficient codes past four would alias, so they read zero
    assign dsp_idx_ok = (dsp_idx < `EQCA_MAP_WORDS)
        && (dsp_req_i.pre || (dsp_req_i.band < 3'h5 && dsp_req_i.coef < 3'h5));
    // ****************************************************************
    // host access sequencing
    // ****************************************************************
    wire logic port_free;
    wire logic idx_ok;
    wire logic [5:0] mem_idx;
    wire logic commit_wr;
    wire logic commit_rd;
    assign port_free = !dsp_req_i.busy;
    assign idx_ok = index_reg[INDEX_W-1:0] < `EQCA_WORDS;
    assign mem_idx = index_reg[5:0];
    // write goes first when both launch bits are set
    assign commit_wr = (state_reg == eqca_pkg::EQCA_PEND) && ctrl_reg[`EQCA_BIT_WR]
        && port_free;
    assign commit_rd = (state_reg == eqca_pkg::EQCA_PEND) && !ctrl_reg[`EQCA_BIT_WR]
        && ctrl_reg[`EQCA_BIT_RD] && port_free;
    // ****************************************************************
    // axi write path
    // ****************************************************************
    wire logic take_aw;
    wire logic take_w;
    wire logic do_write;
    wire logic aw_have_next;
    wire logic w_have_next;
    wire logic bvalid_next;
    wire logic [31:0] wmask;
    wire logic wr_hit_whold;
    wire logic wr_hit_index;
    wire logic wr_hit_ctrl;
    wire logic wr_mapped;
    assign take_aw = awvalid_i && awready_reg;
    assign take_w = wvalid_i && wready_reg;
    assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
    assign aw_have_next = take_aw || (aw_have_reg && !do_write);
    assign w_have_next = take_w || (w_have_reg && !do_write);
    assign bvalid_next = do_write || (bvalid_reg && !bready_i);
    assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
        {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    assign wr_hit_whold = do_write && aw_addr_reg == `EQCA_OFF_WHOLD;
    assign wr_hit_index = do_write && aw_addr_reg == `EQCA_OFF_INDEX;
    assign wr_hit_ctrl = do_write && aw_addr_reg == `EQCA_OFF_CTRL;
    // the read holding register is read-only, so a write to it is refused
    assign wr_mapped = wr_hit_whold || wr_hit_index || wr_hit_ctrl;
    // ****************************************************************
    // register next values
    // ****************************************************************
    wire logic [31:0] whold_merge;
    wire logic [31:0] index_merge;
    wire logic [31:0] ctrl_merge;
    wire logic [DATA_W-1:0] whold_next;
    wire logic [15:0] index_next;
    wire logic [15:0] ctrl_next;
    wire logic set_wr;
    wire logic set_rd;
    wire logic wr_bit_next;
    wire logic rd_bit_next;
    wire logic [DATA_W-1:0] rhold_next;
    eqca_pkg::eqca_state_t state_next;
    assign whold_merge = ({8'h00, whold_reg} & ~wmask) | (w_data_reg & wmask);
    assign index_merge = ({16'h0000, index_reg} & ~wmask) | (w_data_reg & wmask);
    assign ctrl_merge = ({16'h0000, ctrl_reg} & ~wmask) | (w_data_reg & wmask);
    assign whold_next = wr_hit_whold ? whold_merge[DATA_W-1:0] : whold_reg;
    assign index_next = wr_hit_index ? index_merge[15:0] : index_reg;
    // a launch bit is only set by writing one; a set in the clearing cycle wins
    assign set_wr = wr_hit_ctrl && w_strb_reg[1] && w_data_reg[`EQCA_BIT_WR];
    assign set_rd = wr_hit_ctrl && w_strb_reg[1] && w_data_reg[`EQCA_BIT_RD];
    assign wr_bit_next = set_wr || (ctrl_reg[`EQCA_BIT_WR] && !commit_wr);
    assign rd_bit_next = set_rd || (ctrl_reg[`EQCA_BIT_RD] && !commit_rd);
    assign ctrl_next = {wr_bit_next, rd_bit_next,
        wr_hit_ctrl ? ctrl_merge[13:0] : ctrl_reg[13:0]};
    // out-of-range reads return zero rather than an aliased word
    assign rhold_next = commit_rd ? (idx_ok ? mem[mem_idx] : `EQCA_RST_WORD)
        : rhold_reg;
    // ****************************************************************
    // axi read path
    // ****************************************************************
    wire logic take_ar;
    wire logic rvalid_next;
    wire logic [31:0] rd_mux;
    wire logic rd_mapped;
    assign take_ar = arvalid_i && arready_reg;
    assign rvalid_next = take_ar || (rvalid_reg && !rready_i);
    assign rd_mux = (araddr_i == `EQCA_OFF_WHOLD) ? {8'h00, whold_reg} :
        (araddr_i == `EQCA_OFF_RHOLD) ? {8'h00, rhold_reg} :
        (araddr_i == `EQCA_OFF_INDEX) ? {16'h0000, index_reg} :
        (araddr_i == `EQCA_OFF_CTRL) ? {16'h0000, ctrl_reg} : `EQCA_RST_BUS;
    assign rd_mapped = araddr_i == `EQCA_OFF_WHOLD || araddr_i == `EQCA_OFF_RHOLD
        || araddr_i == `EQCA_OFF_INDEX || araddr_i == `EQCA_OFF_CTRL;
    // ****************************************************************
    // sequencer state
    // ****************************************************************
    always_comb
    begin
        case (state_reg)
            eqca_pkg::EQCA_IDLE: state_next = (wr_bit_next || rd_bit_next) ?
                eqca_pkg::EQCA_PEND : eqca_pkg::EQCA_IDLE;
            eqca_pkg::EQCA_PEND: state_next = (wr_bit_next || rd_bit_next) ?
                eqca_pkg::EQCA_PEND : eqca_pkg::EQCA_IDLE;
            default: state_next = eqca_pkg::EQCA_IDLE;
        endcase
    end
    // ****************************************************************
    // flip-flops
    // ****************************************************************
    // software registers and the access sequencer
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            whold_reg <= `EQCA_RST_WORD;
            rhold_reg <= `EQCA_RST_WORD;
            index_reg <= `EQCA_RST_HALF;
            ctrl_reg <= `EQCA_RST_HALF;
            state_reg <= eqca_pkg::EQCA_IDLE;
        end
        else
        begin
            whold_reg <= whold_next;
            rhold_reg <= rhold_next;
            index_reg <= index_next;
            ctrl_reg <= ctrl_next;
            state_reg <= state_next;
        end
    end
    // single port: the audio engine reads, else a committed host write lands
    always_ff @(posedge clock_i)
    begin
        if (commit_wr && idx_ok)
            mem[mem_idx] <= whold_reg;
    end
    // audio engine read data, zero while idle or out of map
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            dsp_rdata_reg <= `EQCA_RST_WORD;
        else
            dsp_rdata_reg <= (dsp_req_i.busy && dsp_idx_ok) ?
                mem[dsp_idx[5:0]] : `EQCA_RST_WORD;
    end
    // write channels of the bus slave
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_data_reg <= `EQCA_RST_BUS;
            w_strb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `EQCA_RESP_OK;
        end
        else
        begin
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            aw_addr_reg <= take_aw ? {awaddr_i[3:2], 2'b00} : aw_addr_reg;
            w_data_reg <= take_w ? wdata_i : w_data_reg;
            w_strb_reg <= take_w ? wstrb_i : w_strb_reg;
            awready_reg <= !aw_have_next && !bvalid_next;
            wready_reg <= !w_have_next && !bvalid_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= do_write ? (wr_mapped ? `EQCA_RESP_OK : `EQCA_RESP_ERR)
                : bresp_reg;
        end
    end
    // read channels of the bus slave
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= `EQCA_RST_BUS;
            rresp_reg <= `EQCA_RESP_OK;
        end
        else
        begin
            arready_reg <= !rvalid_next && !take_ar;
            rvalid_reg <= rvalid_next;
            rdata_reg <= take_ar ? rd_mux : rdata_reg;
            rresp_reg <= take_ar ? (rd_mapped ? `EQCA_RESP_OK : `EQCA_RESP_ERR)
                : rresp_reg;
        end
    end
    // ****************************************************************
    // outputs
    // ****************************************************************
    assign awready_o = awready_reg;
    assign wready_o = wready_reg;
    assign bvalid_o = bvalid_reg;
    assign bresp_o = bresp_reg;
    assign arready_o = arready_reg;
    assign rvalid_o = rvalid_reg;
    assign rdata_o = rdata_reg;
    assign rresp_o = rresp_reg;
    assign dsp_rdata_o = dsp_rdata_reg;
    // ****************************************************************
    // checks
    // ****************************************************************
    // a committed in-range write lands the holding word at the index
    a_write_lands: assert property (@(posedge clock_i) disable iff (rst_i)
        commit_wr && idx_ok |=> mem[$past(mem_idx)] == $past(whold_reg))
        else $error("committed write did not land");
    // write launch bit drops right after its commit unless set again
    a_write_self_clear: assert property (@(posedge clock_i) disable iff (rst_i)
        commit_wr && !set_wr |=> !ctrl_reg[`EQCA_BIT_WR])
        else $error("write launch bit not cleared");
    // the audio engine keeps the port: no commit while it is busy
    a_dsp_priority: assert property (@(posedge clock_i) disable iff (rst_i)
        dsp_req_i.busy |-> !commit_wr && !commit_rd)
        else $error("host access took the port from the audio engine");
    // a pending write with an idle port commits within one cycle
    a_write_progress: assert property (@(posedge clock_i) disable iff (rst_i)
        ctrl_reg[`EQCA_BIT_WR] && !dsp_req_i.busy |-> ##[0:1] commit_wr)
        else $error("pending write stalled on an idle port");
    // a read copies the word, then its launch bit is low
    a_read_copies: assert property (@(posedge clock_i) disable iff (rst_i)
        commit_rd && idx_ok && !set_rd |=>
        rhold_reg == mem[$past(mem_idx)] && !ctrl_reg[`EQCA_BIT_RD])
        else $error("read result or launch clear wrong");
    // the read holding register moves only on a read commit
    a_rhold_stable: assert property (@(posedge clock_i) disable iff (rst_i)
        !commit_rd |=> $stable(rhold_reg))
        else $error("read holding register changed without a read");
    // out-of-range read gives zero and still clears its bit
    a_oor_read: assert property (@(posedge clock_i) disable iff (rst_i)
        commit_rd && !idx_ok && !set_rd |=> rhold_reg == `EQCA_RST_WORD
        && !ctrl_reg[`EQCA_BIT_RD])
        else $error("out-of-range read mishandled");
    // an out-of-range write must not land on the word that its low bits alias
    a_oor_write_kept: assert property (@(posedge clock_i) disable iff (rst_i)
        commit_wr && !idx_ok && {4'h0, mem_idx} < `EQCA_WORDS
        |=> mem[$past(mem_idx)] == $past(mem[mem_idx]))
        else $error("out-of-range write reached the array");
    // channel 1 band words sit in 0x19 to 0x31
    a_chan1_window: assert property (@(posedge clock_i) disable iff (rst_i)
        dsp_req_i.busy && dsp_idx_ok && dsp_req_i.chan && !dsp_req_i.pre
        |-> dsp_idx >= 7'h19 && dsp_idx <= 7'h31)
        else $error("channel 1 word outside its window");
    // band one of channel 0 starts at word 5
    a_band_start: assert property (@(posedge clock_i) disable iff (rst_i)
        !dsp_req_i.pre && !dsp_req_i.chan && dsp_req_i.band == 3'h1
        && dsp_req_i.coef == 3'h0 |-> dsp_idx == 7'h05)
        else $error("band one start misplaced");
    // prescalers at words 0x32 and 0x33
    a_prescaler_word: assert property (@(posedge clock_i) disable iff (rst_i)
        dsp_req_i.pre |-> dsp_idx == (dsp_req_i.chan ? 7'h33 : 7'h32))
        else $error("prescaler word misplaced");
endmodule
`default_nettype wire

// >>> sim/eqca_host_model.sv
// axi4-lite host model that loads and launches coefficient accesses
`timescale 1ns/1ns
`default_nettype none
module eqca_host_model (
    // clock
    input wire logic clock_i,
    // write channels
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [3:0] awaddr_o,
    output logic wvalid_o,
    input wire logic wready_i,
    output logic [31:0] wdata_o,
    output logic [3:0] wstrb_o,
    input wire logic bvalid_i,
    output logic bready_o,
    input wire logic [1:0] bresp_i,
    // read channels
    output logic arvalid_o,
    input wire logic arready_i,
    output logic [3:0] araddr_o,
    input wire logic rvalid_i,
    output logic rready_o,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i
);
    // bus idle at time zero
    initial
    begin
        {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} <= 5'h00;
        {awaddr_o, araddr_o, wdata_o} <= 40'h0;
        wstrb_o <= 4'hf;
    end
    // address and data offered together; a released payload shows its inverse, not a stale copy
    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clock_i);
        {awvalid_o, awaddr_o, wvalid_o, wdata_o, bready_o} <= {1'b1, a, 1'b1, d, 1'b1};
        forever
        begin
            @(posedge clock_i);
            if (awready_i) {awvalid_o, awaddr_o} <= {1'b0, ~a};
            if (wready_i) {wvalid_o, wdata_o} <= {1'b0, ~d};
            if (bvalid_i)
            begin
                r = bresp_i;
                bready_o <= 1'b0;
                break;
            end
        end
    endtask
    // address held until taken, data captured at the rvalid edge
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock_i);
        {arvalid_o, araddr_o, rready_o} <= {1'b1, a, 1'b1};
        forever
        begin
            @(posedge clock_i);
            if (arready_i) {arvalid_o, araddr_o} <= {1'b0, ~a};
            if (rvalid_i)
            begin
                {d, r} = {rdata_i, rresp_i};
                rready_o <= 1'b0;
                break;
            end
        end
    endtask
    // wait for a launch bit to drop; nothing else is touched meanwhile
    task automatic poll(input int b);
        logic [31:0] d;
        logic [1:0] r;
        d = 32'hffffffff;
        while (d[b] !== 1'b0) rd(4'hc, d, r);
    endtask
    // full indirect write of one coefficient word
    task automatic coef_wr(input logic [9:0] i, input logic [23:0] v);
        logic [1:0] r;
        wr(4'h0, {8'h00, v}, r);
        wr(4'h8, {22'h0, i}, r);
        wr(4'hc, 32'h00008000, r);
        poll(15);
    endtask
    // full indirect read of one coefficient word
    task automatic coef_rd(input logic [9:0] i, output logic [23:0] v);
        logic [31:0] d;
        logic [1:0] r;
        wr(4'h8, {22'h0, i}, r);
        wr(4'hc, 32'h00004000, r);
        poll(14);
        rd(4'h4, d, r);
        v = d[23:0];
    endtask
endmodule
`default_nettype wire

// >>> sim/eqca_test.sv
// self-checking testbench for the equalizer coefficient access port
`timescale 1ns/1ns
`default_nettype none
module eqca_test;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [23:0] v, dsp_rdata;
    int err_total = 0;
    int checks = 0;
    eqca_pkg::eqca_dsp_req_t dsp = '0;
    // corner words and the engine request {busy,pre,chan,band,coef} that reaches each
    logic [9:0] idx [7] = '{10'h000, 10'h005, 10'h018, 10'h019, 10'h031, 10'h032, 10'h033};
    eqca_pkg::eqca_dsp_req_t req [7] = '{9'h100, 9'h108, 9'h124, 9'h140, 9'h164, 9'h180, 9'h1c0};
    always #25 clock = ~clock;
    eqca_top u_eqca_top (
        .clock_i(clock), .rst_i(rst), .awvalid_i(awvalid), .awready_o(awready),
        .awaddr_i(awaddr), .wvalid_i(wvalid), .wready_o(wready), .wdata_i(wdata),
        .wstrb_i(wstrb), .bvalid_o(bvalid), .bready_i(bready), .bresp_o(bresp),
        .arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr), .rvalid_o(rvalid),
        .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp), .dsp_req_i(dsp),
        .dsp_rdata_o(dsp_rdata));
    eqca_host_model u_eqca_host_model (
        .clock_i(clock), .awvalid_o(awvalid), .awready_i(awready), .awaddr_o(awaddr),
        .wvalid_o(wvalid), .wready_i(wready), .wdata_o(wdata), .wstrb_o(wstrb),
        .bvalid_i(bvalid), .bready_o(bready), .bresp_i(bresp), .arvalid_o(arvalid),
        .arready_i(arready), .araddr_o(araddr), .rvalid_i(rvalid), .rready_o(rready),
        .rdata_i(rdata), .rresp_i(rresp));
    // distinct pattern per word so a wrong index shows up
    function automatic logic [23:0] pat(input int i);
        return {4'h8, i[3:0], 8'h5a, idx[i][7:0]};
    endfunction
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        for (int a = 0; a < 16; a += 4)
        begin
            u_eqca_host_model.rd(a[3:0], d, r);
            check("reset value", d, 32'h0);
            check("read response", {30'h0, r}, 32'h0);
        end
        $display("test reset values done");
        for (int i = 0; i < 7; i++) u_eqca_host_model.coef_wr(idx[i], pat(i));
        for (int i = 0; i < 7; i++)
        begin
            u_eqca_host_model.coef_rd(idx[i], v);
            check("host readback", {8'h0, v}, {8'h0, pat(i)});
            @(posedge clock);
            dsp <= req[i];
            repeat (2) @(posedge clock);
            dsp <= '0;
            // the word launched at this edge still used the request, so look once it settles
            #1 check("engine word", {8'h0, dsp_rdata}, {8'h0, pat(i)});
        end
        $display("test coefficient map done");
        // engine keeps the port busy, so the launched write must wait
        @(posedge clock);
        dsp <= req[0];
        u_eqca_host_model.wr(4'h0, 32'h00a5c3e1, r);
        u_eqca_host_model.wr(4'h8, 32'h00000000, r);
        u_eqca_host_model.wr(4'hc, 32'h00008000, r);
        check("launch response", {30'h0, r}, 32'h0);
        repeat (20) @(posedge clock);
        u_eqca_host_model.rd(4'hc, d, r);
        check("launch held", {31'h0, d[15]}, 32'h1);
        dsp <= '0;
        #1 check("engine unharmed", {8'h0, dsp_rdata}, {8'h0, pat(0)});
        u_eqca_host_model.poll(15);
        #1 check("engine idle word", {8'h0, dsp_rdata}, 32'h0);
        u_eqca_host_model.coef_rd(10'h000, v);
        check("deferred write", {8'h0, v}, 32'h00a5c3e1);
        $display("test engine priority done");
        // index width and words beyond the array; 0x073 aliases word 0x33 if cut to 6 bits
        u_eqca_host_model.wr(4'h8, 32'hffffffff, r);
        u_eqca_host_model.rd(4'h8, d, r);
        check("index width", d, 32'h0000ffff);
        u_eqca_host_model.coef_wr(10'h073, 24'h123456);
        u_eqca_host_model.coef_rd(10'h034, v);
        check("beyond last word", {8'h0, v}, 32'h0);
        u_eqca_host_model.coef_rd(10'h3ff, v);
        check("top index", {8'h0, v}, 32'h0);
        u_eqca_host_model.coef_rd(10'h033, v);
        check("last word kept", {8'h0, v}, {8'h0, pat(6)});
        // read holding refuses writes
        u_eqca_host_model.wr(4'h4, 32'h00ffffff, r);
        check("holding write refused", {30'h0, r}, 32'h2);
        u_eqca_host_model.rd(4'h4, d, r);
        check("holding unchanged", d, {8'h0, pat(6)});
        $display("test range and access kinds done");
        print_verdict();
    end
    // the tests need well under 5000 cycles; a hang ends here
    initial
    begin
        #(5000 * 50);
        err_total++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule
`default_nettype wire
